/* File: hdl/mbp_regs.svh */
// mbp_regs.svh: configuration bit positions, reset values and counts
// assumes: included by bare name by the package and design modules
`ifndef MBP_REGS_SVH
`define MBP_REGS_SVH
`define MBP_DATA_W          8
`define MBP_CFG_MUX_BIT     0
`define MBP_CFG_RSTPOL_BIT  1
`define MBP_CFG_ALEPOL_BIT  2
`define MBP_CFG_DIFFRD_BIT  3
`define MBP_CFG_SEPSP_BIT   4
`define MBP_CFG_W           5
`define MBP_CFG_RESET       5'h0F
`define MBP_SRAM_DEPTH      2048
`define MBP_SRAM_AW         11
`define MBP_PROG_AW         8
`define MBP_STROBE_CYC      4
// erased program store reads all ones
`define MBP_PROG_BLANK      8'hFF
`endif

/* File: hdl/mbp_pkg.sv */
// mbp_pkg.sv: types shared by both ends of the bus port
// assumes: mbp_regs.svh on the include path
`include "mbp_regs.svh"
package mbp_pkg;
  typedef enum logic {MBP_AUX_SELECT_OUT, MBP_AUX_ADDR_IN} mbp_aux_dir_t;
  typedef enum logic {MBP_TERM_LOGIC, MBP_TERM_ADDR} mbp_aux_term_t;
  typedef enum logic {MBP_TOP_ADDR, MBP_TOP_POWERDOWN} mbp_top_mode_t;
  typedef enum logic {MBP_PORTA_ADDR_IO, MBP_PORTA_TRACK} mbp_porta_mode_t;
  typedef enum logic {MBP_DRV_CMOS, MBP_DRV_OPEN_DRAIN} mbp_drv_t;
endpackage : mbp_pkg

/* File: hdl/mbp_bus_if.sv */
// mbp_bus_if.sv: pin-level bus between host and peripheral port
// assumes: bench resolves the shared low lines from the enables
`timescale 1ns/1ps
`default_nettype none
interface mbp_bus_if;
  logic [7:0] ad_host_out;
  logic       ad_host_oe;
  logic [7:0] ad_dev_out;
  logic       ad_dev_oe;
  logic [7:0] ad_in;
  logic [7:0] addr_high;
  logic       latch_strobe;
  logic       rd_strobe_n;
  logic       program_store_read_strobe_n;
  logic       wr_strobe_n;
  logic       reset_pin;
  modport host (output ad_host_out, ad_host_oe, addr_high, latch_strobe, rd_strobe_n,
                program_store_read_strobe_n, wr_strobe_n, reset_pin, input ad_in);
  modport dev (output ad_dev_out, ad_dev_oe, input ad_in, addr_high, latch_strobe,
               rd_strobe_n, program_store_read_strobe_n, wr_strobe_n, reset_pin);
endinterface : mbp_bus_if
`default_nettype wire

/* File: hdl/mbp_sync.sv */
// mbp_sync.sv: two flip-flop synchroniser for a bundle of pins
// assumes: CORE_CLK domain, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module mbp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : mbp_sync
`default_nettype wire

/* File: hdl/mbp_host.sv */
// mbp_host.sv: host end; runs one bus cycle per AXI4-Lite write to offset 0 taken while idle
// assumes: CORE_CLK 125 MHz, device attached through mbp_bus_if
`timescale 1ns/1ps
`default_nettype none
`include "mbp_regs.svh"
module mbp_host
  import mbp_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  mbp_bus_if.host          BUS,
  input  wire logic [3:0]  S_AWADDR,
  input  wire logic        S_AWVALID,
  output var  logic        S_AWREADY,
  input  wire logic [31:0] S_WDATA,
  input  wire logic [3:0]  S_WSTRB,
  input  wire logic        S_WVALID,
  output var  logic        S_WREADY,
  output var  logic [1:0]  S_BRESP,
  output var  logic        S_BVALID,
  input  wire logic        S_BREADY,
  input  wire logic [3:0]  S_ARADDR,
  input  wire logic        S_ARVALID,
  output var  logic        S_ARREADY,
  output var  logic [31:0] S_RDATA,
  output var  logic [1:0]  S_RRESP,
  output var  logic        S_RVALID,
  input  wire logic        S_RREADY
);
  // command word: [15:0] address, [23:16] data, [24] write, [25] program read,
  // [26] reset pin level; writing starts a cycle at offset 0, status at 4
  typedef enum logic [2:0] {H_IDLE, H_ALE, H_GAP, H_STROBE, H_DONE} mbp_hstate_t;
  mbp_hstate_t state_reg;
  logic [26:0] cmd_reg;
  logic [26:0] wdata_reg;
  logic [7:0]  rdata_reg;
  logic [2:0]  cnt_reg;
  logic        aw_got_reg, w_got_reg, wsel_reg;
  logic        busy;
  assign busy = (state_reg != H_IDLE);

  // ------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_AWREADY  <= 1'b1;
      S_WREADY   <= 1'b1;
      S_BVALID   <= 1'b0;
      S_BRESP    <= 2'h0;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      wsel_reg   <= 1'b0;
      cmd_reg    <= 27'h4000000;
      wdata_reg  <= 27'h0;
    end
    else
    begin
      if (S_AWVALID && S_AWREADY)
      begin
        aw_got_reg <= 1'b1;
        S_AWREADY  <= 1'b0;
        wsel_reg   <= (S_AWADDR[3:2] == 2'h0);
      end
      if (S_WVALID && S_WREADY)
      begin
        w_got_reg <= 1'b1;
        S_WREADY  <= 1'b0;
        wdata_reg <= S_WDATA[26:0];
      end
      // commit only a write to offset 0 that starts a bus cycle
      if (aw_got_reg && w_got_reg && wsel_reg && !S_BVALID && !busy)
        cmd_reg <= wdata_reg;
      if (aw_got_reg && w_got_reg && !S_BVALID)
      begin
        S_BVALID <= 1'b1;
        S_BRESP  <= wsel_reg ? 2'h0 : 2'h2;
      end
      if (S_BVALID && S_BREADY)
      begin
        S_BVALID   <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        S_AWREADY  <= 1'b1;
        S_WREADY   <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      S_ARREADY <= 1'b1;
      S_RVALID  <= 1'b0;
      S_RDATA   <= 32'h0;
      S_RRESP   <= 2'h0;
    end
    else if (S_ARVALID && S_ARREADY)
    begin
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b1;
      S_RRESP   <= (S_ARADDR[3:2] < 2'h2) ? 2'h0 : 2'h2;
      case (S_ARADDR[3:2])
        2'h0:    S_RDATA <= {5'h0, cmd_reg};
        2'h1:    S_RDATA <= {23'h0, busy, rdata_reg};
        default: S_RDATA <= 32'h0;
      endcase
    end
    else if (S_RVALID && S_RREADY)
    begin
      S_RVALID  <= 1'b0;
      S_ARREADY <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // bus cycle sequencer
  // ------------------------------------------------------------
  logic start;
  assign start = aw_got_reg && w_got_reg && wsel_reg && !S_BVALID && !busy;

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_reg             <= H_IDLE;
      cnt_reg               <= 3'h0;
      rdata_reg             <= 8'h0;
      BUS.ad_host_out       <= 8'h0;
      BUS.ad_host_oe        <= 1'b0;
      BUS.addr_high         <= 8'h0;
      BUS.latch_strobe      <= 1'b0;
      BUS.rd_strobe_n       <= 1'b1;
      BUS.program_store_read_strobe_n <= 1'b1;
      BUS.wr_strobe_n       <= 1'b1;
      BUS.reset_pin         <= 1'b1;
    end
    else
    begin
      BUS.reset_pin <= cmd_reg[26];
      case (state_reg)
        H_IDLE:
          if (start)
          begin
            state_reg        <= H_ALE;
            BUS.ad_host_out  <= wdata_reg[7:0];
            BUS.ad_host_oe   <= 1'b1;
            BUS.addr_high    <= wdata_reg[15:8];
            BUS.latch_strobe <= 1'b1;
          end
        H_ALE:
        begin
          state_reg        <= H_GAP;
          BUS.latch_strobe <= 1'b0;
          BUS.ad_host_oe   <= 1'b0;
        end
        H_GAP:
        begin
          state_reg <= H_STROBE;
          cnt_reg   <= 3'h0;
          if (cmd_reg[24])
          begin
            BUS.ad_host_out <= cmd_reg[23:16];
            BUS.ad_host_oe  <= 1'b1;
            BUS.wr_strobe_n <= 1'b0;
          end
          else if (cmd_reg[25])
            BUS.program_store_read_strobe_n <= 1'b0;
          else
            BUS.rd_strobe_n <= 1'b0;
        end
        H_STROBE:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(`MBP_STROBE_CYC - 1))
          begin
            state_reg <= H_DONE;
            rdata_reg <= BUS.ad_in;
            BUS.wr_strobe_n <= 1'b1;
            BUS.rd_strobe_n <= 1'b1;
            BUS.program_store_read_strobe_n <= 1'b1;
          end
        end
        H_DONE:
        begin
          state_reg      <= H_IDLE;
          BUS.ad_host_oe <= 1'b0;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end
endmodule : mbp_host
`default_nettype wire

/* File: hdl/mbp_device.sv */
// mbp_device.sv: peripheral end; bus decode, memories and pin functions
// Notes on behaviour
// - low lines carry address then data
// - upper address taken straight from pins
// - demultiplex only in multiplexed mode
// - data bus is eight bits only
// - reset pin polarity is configurable
// - latch strobe polarity is configurable
// - ram written and read on own strobes
// - distinct strobes pick ram or program
// - separate spaces may overlap addresses
// - separate spaces need distinct read strobes
// - each aux pin: select out or address
// - aux input is logic or address term
// - high address bits usable out of order
// - top pin: address or powerdown select
// - board ties unused aux inputs low
// - port a: address/io or tracking mode
// - port a pin: address copy or io
// - port b pin: select output or io
// assumes: pins arrive asynchronously, CORE_CLK 125 MHz
`timescale 1ns/1ps
`default_nettype none
`include "mbp_regs.svh"
module mbp_device
  import mbp_pkg::*;
#(
  parameter int DATA_W = `MBP_DATA_W
)
(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RESET_N,
  mbp_bus_if.dev                     BUS,
  input  wire logic [`MBP_CFG_W-1:0] CFG_BITS,
  input  wire logic [2:0]            AUX_DIR,
  input  wire logic [2:0]            AUX_TERM,
  input  wire logic [2:0]            AUX_IN,
  input  wire logic [2:0]            AUX_SELECT_EQ,
  output var  logic [2:0]            AUX_OUT,
  output var  logic [2:0]            AUX_OE,
  input  wire logic                  TOP_ADDR_OR_POWERDOWN_SELECT,
  input  wire logic                  TOP_MODE,
  output var  logic                  POWERDOWN,
  output var  logic [19:16]          HIGH_ADDR,
  output var  logic [2:0]            LOGIC_TERMS,
  input  wire logic                  PORTA_MODE,
  input  wire logic [7:0]            PORTA_ADDR_SEL,
  input  wire logic [7:0]            PORTA_DRV,
  input  wire logic [7:0]            PORTA_IO_OUT,
  output var  logic [7:0]            PORTA_OUT,
  output var  logic [7:0]            PORTA_OE,
  input  wire logic [7:0]            PORTB_CS_SEL,
  input  wire logic [7:0]            PORTB_SELECT_EQ,
  input  wire logic [7:0]            PORTB_IO_OUT,
  output var  logic [7:0]            PORTB_OUT,
  output var  logic                  IN_RESET
);
  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [7:0] ad_s, ah_s, aux_s;
  logic       ale_s, rd_s, program_store_read_strobe_s, wr_s, rst_s, top_s;
  logic [1:0] ah_unused;
  // synced pins reset to their idle levels: read and write strobes and reset pin high, latch strobe low
  mbp_sync #(.W(32), .RST_VAL(32'h0000_0078)) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     ({BUS.ad_in, BUS.addr_high, 5'h0, AUX_IN, BUS.latch_strobe, BUS.rd_strobe_n,
             BUS.program_store_read_strobe_n, BUS.wr_strobe_n, BUS.reset_pin,
             TOP_ADDR_OR_POWERDOWN_SELECT, 2'h0}),
    .q     ({ad_s, ah_s, aux_s, ale_s, rd_s, program_store_read_strobe_s, wr_s, rst_s, top_s, /* pad */ ah_unused})
  );
  logic mux_mode, rst_hi, ale_hi, diff_rd, sep_sp;
  assign mux_mode = CFG_BITS[`MBP_CFG_MUX_BIT];
  assign rst_hi   = CFG_BITS[`MBP_CFG_RSTPOL_BIT];
  assign ale_hi   = CFG_BITS[`MBP_CFG_ALEPOL_BIT];
  assign diff_rd  = CFG_BITS[`MBP_CFG_DIFFRD_BIT];
  assign sep_sp   = diff_rd & CFG_BITS[`MBP_CFG_SEPSP_BIT];

  logic dev_rst, ale_act, rd_act, program_store_read_strobe_act, wr_act;
  assign dev_rst  = rst_s ~^ rst_hi;
  assign ale_act  = ale_s ~^ ale_hi;
  assign rd_act   = ~rd_s;
  assign program_store_read_strobe_act = ~program_store_read_strobe_s;
  assign wr_act   = ~wr_s;

  // --------------------------------------------------------------
  // address latch and memories
  // --------------------------------------------------------------
  logic [7:0] alow_reg;
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      alow_reg <= 8'h0;
    else if (ale_act && mux_mode)
      alow_reg <= ad_s;
  end

  logic [15:0] addr;
  assign addr = {ah_s, mux_mode ? alow_reg : ad_s};

  logic [DATA_W-1:0] sram [0:`MBP_SRAM_DEPTH-1];
  logic [DATA_W-1:0] prog [0:(1<<`MBP_PROG_AW)-1];
  logic              wr_d_reg;
  // nothing in this block programs the store, so it reads as erased
  always_comb prog = '{default: `MBP_PROG_BLANK};
  logic              ram_hit, prog_hit, ram_rd, prog_rd;
  // overlapping addresses: strobe decides in separate mode
  assign ram_hit  = sep_sp ? 1'b1 : (addr[15] == 1'b0);
  assign prog_hit = sep_sp ? 1'b1 : (addr[15] == 1'b1);
  assign ram_rd   = diff_rd ? (rd_act & ram_hit) : ((rd_act | program_store_read_strobe_act) & ram_hit);
  assign prog_rd  = diff_rd ? (program_store_read_strobe_act & prog_hit) : ((rd_act | program_store_read_strobe_act) & prog_hit);

  always_ff @(posedge CORE_CLK)
  begin
    if (wr_act && !wr_d_reg && ram_hit && !dev_rst && !POWERDOWN)
      sram[addr[`MBP_SRAM_AW-1:0]] <= ad_s;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      wr_d_reg       <= 1'b0;
      BUS.ad_dev_out <= 8'h0;
      BUS.ad_dev_oe  <= 1'b0;
      IN_RESET       <= 1'b1;
    end
    else
    begin
      wr_d_reg  <= wr_act;
      IN_RESET  <= dev_rst;
      BUS.ad_dev_oe <= (ram_rd | prog_rd) & !dev_rst & !POWERDOWN;
      if (ram_rd)
        BUS.ad_dev_out <= sram[addr[`MBP_SRAM_AW-1:0]];
      else if (prog_rd)
        BUS.ad_dev_out <= prog[addr[`MBP_PROG_AW-1:0]];
    end
  end

  // --------------------------------------------------------------
  // aux select pins and top pin
  // --------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_aux
      always_ff @(posedge CORE_CLK or negedge RESET_N)
      begin
        if (!RESET_N)
        begin
          AUX_OUT[i]     <= 1'b0;
          AUX_OE[i]      <= 1'b0;
          HIGH_ADDR[16+i] <= 1'b0;
          LOGIC_TERMS[i] <= 1'b0;
        end
        else
        begin
          // pin i is select 8+i when output, address 16+i or logic term i when input
          AUX_OE[i]  <= (AUX_DIR[i] == MBP_AUX_SELECT_OUT);
          AUX_OUT[i] <= AUX_SELECT_EQ[i];
          // each address bit stands alone, so gaps are fine
          HIGH_ADDR[16+i] <= (AUX_DIR[i] == MBP_AUX_ADDR_IN) &&
                             (AUX_TERM[i] == MBP_TERM_ADDR) && aux_s[i];
          LOGIC_TERMS[i]  <= (AUX_DIR[i] == MBP_AUX_ADDR_IN) &&
                             (AUX_TERM[i] == MBP_TERM_LOGIC) && aux_s[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      HIGH_ADDR[19] <= 1'b0;
      POWERDOWN     <= 1'b0;
    end
    else
    begin
      HIGH_ADDR[19] <= (TOP_MODE == MBP_TOP_ADDR) & top_s;
      POWERDOWN     <= (TOP_MODE == MBP_TOP_POWERDOWN) & top_s;
    end
  end

  // --------------------------------------------------------------
  // general ports a and b
  // --------------------------------------------------------------
  generate
    for (i = 0; i < 8; i++)
    begin : g_port
      logic pa_val;
      // tracking mode follows the low bus lines
      assign pa_val = (PORTA_MODE == MBP_PORTA_TRACK) ? ad_s[i] :
                      (PORTA_ADDR_SEL[i] ? alow_reg[i] : PORTA_IO_OUT[i]);
      always_ff @(posedge CORE_CLK or negedge RESET_N)
      begin
        if (!RESET_N)
        begin
          PORTA_OUT[i] <= 1'b0;
          PORTA_OE[i]  <= 1'b0;
          PORTB_OUT[i] <= 1'b0;
        end
        else
        begin
          PORTA_OUT[i] <= (PORTA_DRV[i] == MBP_DRV_OPEN_DRAIN) ? 1'b0 : pa_val;
          PORTA_OE[i]  <= (PORTA_DRV[i] == MBP_DRV_OPEN_DRAIN) ? !pa_val : 1'b1;
          PORTB_OUT[i] <= PORTB_CS_SEL[i] ? PORTB_SELECT_EQ[i] : PORTB_IO_OUT[i];
        end
      end
    end
  endgenerate
endmodule : mbp_device
`default_nettype wire

/* File: bench/mbp_bus_checker.sv */
// mbp_bus_checker.sv: assertions on the pins between host end and device end
// assumes: instantiated in the bench top beside the interface, CORE_CLK domain only
`timescale 1ns/1ps
`default_nettype none
module mbp_bus_checker
(
  input wire logic       CORE_CLK,
  input wire logic       RESET_N,
  input wire logic [7:0] addr_high,
  input wire logic       ad_host_oe,
  input wire logic       ad_dev_oe,
  input wire logic       latch_strobe,
  input wire logic       rd_strobe_n,
  input wire logic       program_store_read_strobe_n,
  input wire logic       wr_strobe_n
);
  logic any_rd;
  assign any_rd = !rd_strobe_n || !program_store_read_strobe_n;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // ------------------------------------------------------------
  // bus cycle steps
  // ------------------------------------------------------------
  sequence wr_pulse_s;
    !wr_strobe_n [*4] ##1 wr_strobe_n;
  endsequence
  sequence rd_pulse_s;
    any_rd [*4] ##1 !any_rd;
  endsequence
  ale_one_cycle_a: assert property ($rose(latch_strobe) |=> !latch_strobe)
    else $error("latch strobe longer than one cycle");
  ale_to_strobe_a: assert property ($fell(latch_strobe) |-> ##1 (any_rd || !wr_strobe_n))
    else $error("no strobe one cycle after the latch gap");
  wr_width_a: assert property ($fell(wr_strobe_n) |-> wr_pulse_s)
    else $error("write strobe not four cycles");
  rd_width_a: assert property ($rose(any_rd) |-> rd_pulse_s)
    else $error("read strobe not four cycles");
  one_strobe_a: assert property (!(any_rd && !wr_strobe_n) &&
                                 !(!rd_strobe_n && !program_store_read_strobe_n))
    else $error("two strobes active together");
  ale_drives_addr_a: assert property (latch_strobe |->
                                      ad_host_oe && wr_strobe_n && !any_rd)
    else $error("address not driven alone during latch");
  wr_drives_data_a: assert property (!wr_strobe_n |-> ad_host_oe)
    else $error("host not driving data on write");
  read_releases_a: assert property (any_rd |-> !ad_host_oe)
    else $error("host drives low lines during read");
  high_addr_hold_a: assert property ((any_rd || !wr_strobe_n) |-> $stable(addr_high))
    else $error("upper address moved during strobe");
  no_contention_a: assert property (!(ad_host_oe && ad_dev_oe))
    else $error("both ends drive low lines");
  prog_read_c: cover property ($fell(program_store_read_strobe_n));
endmodule : mbp_bus_checker
`default_nettype wire

/* File: bench/mcu_bus_port_config_tb.sv */
// mcu_bus_port_config_tb.sv: host and device joined, host driven over AXI4-Lite
// assumes: design files compiled first; undriven low lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
`include "mbp_regs.svh"
module mcu_bus_port_config_tb
  import mbp_pkg::*;
;
  logic         clk = 1'b0, rst_n = 1'b0;
  logic [3:0]   awaddr = 4'h0, araddr = 4'h0;
  logic [31:0]  wdata = 32'h0, rdata, d;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid, powerdown, in_reset;
  logic [1:0]   bresp, rresp, r;
  logic [4:0]   cfg = 5'h0F;
  // unused aux inputs stay tied low until a test uses them
  logic [2:0]   aux_dir = 3'h0, aux_term = 3'h0, aux_in = 3'h0, aux_eq = 3'h0;
  logic [2:0]   aux_out, aux_oe, logic_terms;
  logic         top_pin = 1'b0, top_mode = 1'b0, pa_mode = 1'b0;
  logic [7:0]   pa_sel = 8'h0, pa_drv = 8'h0, pa_io = 8'h0, pb_sel = 8'h0, pb_eq = 8'h0;
  logic [7:0]   pb_io = 8'h0, pa_out, pa_oe, pb_out, last_ad = 8'h0;
  logic [19:16] high_addr;
  int           n_mismatch = 0, checks_done = 0, cyc = 0;
  always #4 clk = ~clk;
  mbp_bus_if bus ();
  // released low lines show the inverse of what was last driven
  assign bus.ad_in = bus.ad_host_oe ? bus.ad_host_out : bus.ad_dev_oe ? bus.ad_dev_out : ~last_ad;
  always @(posedge clk) if (bus.ad_host_oe || bus.ad_dev_oe) last_ad <= bus.ad_in;
  mbp_host mbp_host_inst (.CORE_CLK(clk), .RESET_N(rst_n), .BUS(bus.host), .S_AWADDR(awaddr),
    .S_AWVALID(awvalid), .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(4'hF),
    .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid),
    .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready),
    .S_RDATA(rdata), .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready));
  mbp_device mbp_device_inst (.CORE_CLK(clk), .RESET_N(rst_n), .BUS(bus.dev), .CFG_BITS(cfg),
    .AUX_DIR(aux_dir), .AUX_TERM(aux_term), .AUX_IN(aux_in), .AUX_SELECT_EQ(aux_eq),
    .AUX_OUT(aux_out), .AUX_OE(aux_oe), .TOP_ADDR_OR_POWERDOWN_SELECT(top_pin),
    .TOP_MODE(top_mode), .POWERDOWN(powerdown), .HIGH_ADDR(high_addr),
    .LOGIC_TERMS(logic_terms), .PORTA_MODE(pa_mode), .PORTA_ADDR_SEL(pa_sel),
    .PORTA_DRV(pa_drv), .PORTA_IO_OUT(pa_io), .PORTA_OUT(pa_out), .PORTA_OE(pa_oe),
    .PORTB_CS_SEL(pb_sel), .PORTB_SELECT_EQ(pb_eq), .PORTB_IO_OUT(pb_io),
    .PORTB_OUT(pb_out), .IN_RESET(in_reset));
  mbp_bus_checker mbp_bus_checker_inst (.CORE_CLK(clk), .RESET_N(rst_n),
    .addr_high(bus.addr_high), .ad_host_oe(bus.ad_host_oe), .ad_dev_oe(bus.ad_dev_oe),
    .latch_strobe(bus.latch_strobe), .rd_strobe_n(bus.rd_strobe_n),
    .program_store_read_strobe_n(bus.program_store_read_strobe_n),
    .wr_strobe_n(bus.wr_strobe_n));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1) @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  // one bus cycle, then wait until the host reports idle
  task automatic cmd(input logic [31:0] w);
    axi_wr(4'h0, w, r);
    repeat (2) @(posedge clk);
    do axi_rd(4'h4, d, r); while (d[8] !== 1'b0);
  endtask : cmd
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(in_reset, 1, "device held by reset pin");
    axi_wr(4'h8, 32'h0, r);
    check(r, 2'b10, "unmapped write");
    axi_rd(4'hC, d, r);
    check(r, 2'b10, "unmapped read");
    check(d, 0, "unmapped read data");
    cmd(32'h0000_0000);
    repeat (4) @(posedge clk);
    check(in_reset, 0, "reset pin released");
    cmd(32'h01A5_0123);
    cmd(32'h013C_0623);
    cmd(32'h0000_0623);
    check(d[7:0], 8'h3C, "ram read high page");
    cmd(32'h0000_0123);
    check(d[7:0], 8'hA5, "ram read");
    cfg <= 5'h1F;
    repeat (4) @(posedge clk);
    cmd(32'h0200_0123);
    check(d[7:0], `MBP_PROG_BLANK, "program read gave ram");
    cmd(32'h0000_0123);
    check(d[7:0], 8'hA5, "ram read in separate spaces");
    // non-multiplexed cycle must leave the latched low address alone
    cfg <= 5'h0E;
    cmd(32'h0000_0045);
    cfg <= 5'h0F;
    pa_sel <= 8'hF0;
    pa_io <= 8'h0D;
    pb_sel <= 8'h0F;
    pb_eq <= 8'hAA;
    pb_io <= 8'h55;
    aux_eq <= 3'b101;
    top_pin <= 1'b1;
    repeat (4) @(posedge clk);
    check(pa_out, 8'h2D, "port a address or io");
    check(pa_oe, 8'hFF, "port a drive");
    check(pb_out, 8'h5A, "port b select or io");
    check({aux_oe, aux_out}, 6'b111101, "aux select outputs");
    check(high_addr[19], 1, "top address out of order");
    check(powerdown, 0, "no powerdown in address mode");
    pa_drv <= 8'h01;
    repeat (4) @(posedge clk);
    check({pa_oe, pa_out}, 16'hFE2C, "port a open drain");
    pa_drv <= 8'h00;
    pa_mode <= 1'b1;
    repeat (4) @(posedge clk);
    check(pa_out, bus.ad_in, "port a tracking");
    aux_dir <= 3'b111;
    aux_term <= 3'b101;
    aux_in <= 3'b111;
    repeat (4) @(posedge clk);
    check(aux_oe, 3'b000, "aux inputs released");
    check(high_addr[18:16], 3'b101, "aux address terms");
    check(logic_terms, 3'b010, "aux logic term");
    cfg <= 5'h0D;
    repeat (4) @(posedge clk);
    check(in_reset, 1, "reset pin active low");
    cfg <= 5'h0F;
    top_mode <= 1'b1;
    repeat (4) @(posedge clk);
    check(powerdown, 1, "powerdown select");
    close_out();
  end
endmodule : mcu_bus_port_config_tb
`default_nettype wire
